// >>> logic/intvec_lowpower_ctrl.sv
// Purpose: interrupt priority, vector selection and low-power clock gating
// Assumes: inputs synchronous to clk_sys, flags held as levels by their peripherals
// Notes:   registers reached over Avalon-MM, one wait state per access
//
// The implementer's own choices: the address map and register access over Avalon-MM.
module intvec_lowpower_ctrl
  import intvec_pkg::*;
#(
  parameter logic [15:0] RAM_TOP   = 16'h02FF,
  parameter logic [15:0] CODE_BASE = 16'hF800
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // event sources
  input  wire src_flags_s  src_flags,
  // cpu side
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        cpu_irq_ack,
  input  wire logic        cpu_irq_return,
  input  wire logic [15:0] boot_vector_word,
  input  wire logic [15:0] bootloader_key_word,
  output logic             irq_req,
  output logic      [15:0] vector_word_addr,
  output logic      [4:0]  irq_priority,
  output logic             fetch_reset,
  output logic             bootloader_disable,
  output logic             bootloader_erase_block,
  // clock system
  output clk_gate_s        clk_gate
);

  // ==========================================================================
  // elaboration checks: refuse a memory map the range check cannot serve
  if (RAM_TOP < RAM_BASE || RAM_TOP >= INFO_BASE) begin : g_bad_ram
    $error("RAM_TOP outside the ram window");
  end
  if (CODE_BASE <= INFO_TOP || CODE_BASE > VEC_REGION_BASE) begin : g_bad_code
    $error("CODE_BASE must lie between info memory and vectors");
  end

  // ==========================================================================
  // state declarations
  power_mode_e          mode_q;
  power_mode_e          saved_mode_q;
  logic                 woke_q;
  logic                 gie_q;
  logic                 dco_in_run_q;
  logic [EN_WIDTH-1:0]  enable_q;
  logic                 boot_check_q;
  logic                 fetch_fault_q;
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic                 req_q;
  logic [15:0]          vaddr_q;
  logic [4:0]           prio_q;
  logic                 fetch_reset_q;
  logic                 bsl_off_q;
  logic                 bsl_noerase_q;
  clk_gate_s            gate_q;
  clk_gate_s            gate_d;
  logic [NUM_VEC-1:0]   vec_raw;
  logic [NUM_VEC-1:0]   vec_req;
  logic                 any_req;
  logic [15:0]          pick_addr;
  logic [4:0]           pick_prio;
  logic                 bad_fetch;
  logic                 wr_take;
  logic                 wake;
  logic [31:0]          status_word;

  // ==========================================================================
  // raw vector requests; flags stay in the peripherals, only ORed here
  // unused low vector words have no entry and are never produced
  assign vec_raw[0] = |src_flags.port1_pin_flags;
  assign vec_raw[1] = |src_flags.port2_pin_flags;
  assign vec_raw[2] = src_flags.converter_done_flag;
  assign vec_raw[3] = src_flags.serial_tx_flag;
  assign vec_raw[4] = src_flags.serial_rx_flag;
  assign vec_raw[5] = src_flags.first_timer_shared_flag;
  assign vec_raw[6] = src_flags.first_timer_ch0_flag;
  assign vec_raw[7] = src_flags.watchdog_interval_flag;
  assign vec_raw[8] = src_flags.second_timer_shared_flag;
  assign vec_raw[9] = src_flags.second_timer_ch0_flag;

  // non-maskable group: own enables only, global enable ignored
  assign vec_raw[VEC_NMI] =
      (src_flags.nonmaskable_pin_flag        & enable_q[EN_NMI_PIN_BIT]) |
      (src_flags.osc_fault_flag              & enable_q[EN_OSC_BIT]) |
      (src_flags.flash_access_violation_flag & enable_q[EN_ACCV_BIT]);

  // every reset cause shares the top vector and cannot be masked
  assign vec_raw[VEC_RESET] = src_flags.power_up_flag |
                              src_flags.ext_reset_flag |
                              src_flags.watchdog_flag |
                              src_flags.flash_key_violation_flag |
                              fetch_fault_q;

  // ==========================================================================
  // masking: maskable vectors need their enable and the global enable
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VEC; gi++) begin : g_mask
      if (gi >= VEC_NMI) begin : g_nm
        assign vec_req[gi] = vec_raw[gi];
      end else begin : g_m
        assign vec_req[gi] = vec_raw[gi] & enable_q[gi] & gie_q;
      end
    end
  endgenerate

  assign any_req = |vec_req;

  // ==========================================================================
  // priority pick: later entries hold higher numbers and win
  always_comb begin
    pick_addr = RESET_VEC_ADDR;
    pick_prio = VEC_PRIO[VEC_RESET];
    for (int i = 0; i < NUM_VEC; i++) begin
      if (vec_req[i]) begin
        pick_addr = VEC_ADDR[i];
        pick_prio = VEC_PRIO[i];
      end
    end
  end

  // ==========================================================================
  // fetch range check: peripheral space and every unpopulated hole
  always_comb begin
    bad_fetch = 1'b0;
    if (fetch_valid) begin
      if (fetch_addr <= PERIPH_TOP) begin
        bad_fetch = 1'b1;
      end else if (fetch_addr > RAM_TOP && fetch_addr < INFO_BASE) begin
        bad_fetch = 1'b1;
      end else if (fetch_addr > INFO_TOP && fetch_addr < CODE_BASE) begin
        bad_fetch = 1'b1;
      end
    end
  end

  // sticky fetch fault; a new fault wins over the clearing ack
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch_fault_q <= 1'b0;
      fetch_reset_q <= 1'b0;
    end else begin
      fetch_reset_q <= bad_fetch;
      if (bad_fetch) begin
        fetch_fault_q <= 1'b1;
      end else if (cpu_irq_ack && prio_q == VEC_PRIO[VEC_RESET]) begin
        fetch_fault_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // bus handshake: one wait cycle, transfer completes when wait drops
  assign wr_take = avs_write && !wait_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      if ((avs_read || avs_write) && wait_q) begin
        wait_q <= 1'b0;
        case (avs_address)
          REG_CTRL:   rdata_q <= {27'h0000000, dco_in_run_q, gie_q, mode_q};
          REG_ENABLE: rdata_q <= {19'h00000, enable_q};
          REG_STATUS: rdata_q <= status_word;
          REG_BOOT:   rdata_q <= {30'h00000000, bsl_noerase_q, bsl_off_q};
          default:    rdata_q <= 32'h0000_0000;
        endcase
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  // status word: pending priority, request, mode, wake state
  assign status_word = {19'h00000, woke_q, 1'b0, mode_q, 2'b00, req_q, prio_q};

  // ==========================================================================
  // configuration writes: global enable, dco use, vector enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gie_q        <= 1'b0;
      dco_in_run_q <= 1'b1;
      enable_q     <= ENABLE_RESET;
    end else if (wr_take) begin
      if (avs_address == REG_CTRL && avs_byteenable[0]) begin
        gie_q        <= avs_writedata[CTRL_GIE_BIT];
        dco_in_run_q <= avs_writedata[CTRL_DCO_BIT];
      end
      if (avs_address == REG_ENABLE) begin
        if (avs_byteenable[0]) begin
          enable_q[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          enable_q[EN_WIDTH-1:8] <= avs_writedata[EN_WIDTH-1:8];
        end
      end
    end
  end

  // ==========================================================================
  // mode control: boot check, wake on request, restore on return, software
  assign wake = any_req && (mode_q != FULL_RUN_MODE) && !woke_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q       <= FULL_RUN_MODE;
      saved_mode_q <= FULL_RUN_MODE;
      woke_q       <= 1'b0;
      boot_check_q <= 1'b1;
    end else begin
      boot_check_q <= 1'b0;
      if (boot_check_q && boot_vector_word == BLANK_WORD) begin
        mode_q <= SLEEP_LEVEL_4;
      end else if (wake) begin
        saved_mode_q <= mode_q;
        mode_q       <= FULL_RUN_MODE;
        woke_q       <= 1'b1;
      end else if (cpu_irq_return && woke_q) begin
        mode_q <= saved_mode_q;
        woke_q <= 1'b0;
      end else if (wr_take && avs_address == REG_CTRL && avs_byteenable[0]) begin
        case (avs_writedata[CTRL_MODE_LSB +: 3])
          3'h0:    mode_q <= FULL_RUN_MODE;
          3'h1:    mode_q <= SLEEP_LEVEL_0;
          3'h2:    mode_q <= SLEEP_LEVEL_1;
          3'h3:    mode_q <= SLEEP_LEVEL_2;
          3'h4:    mode_q <= SLEEP_LEVEL_3;
          3'h5:    mode_q <= SLEEP_LEVEL_4;
          default: mode_q <= mode_q;
        endcase
      end
    end
  end

  // ==========================================================================
  // clock gating per mode
  always_comb begin
    gate_d = '0;
    case (mode_q)
      FULL_RUN_MODE: begin
        gate_d = 6'b111111;
      end
      SLEEP_LEVEL_0: begin
        gate_d.sub_main_clk_en = 1'b1;
        gate_d.aux_clk_en      = 1'b1;
        gate_d.dco_dc_gen_en   = 1'b1;
        gate_d.xtal_en         = 1'b1;
      end
      SLEEP_LEVEL_1: begin
        gate_d.sub_main_clk_en = 1'b1;
        gate_d.aux_clk_en      = 1'b1;
        gate_d.dco_dc_gen_en   = dco_in_run_q;
        gate_d.xtal_en         = 1'b1;
      end
      SLEEP_LEVEL_2: begin
        gate_d.aux_clk_en    = 1'b1;
        gate_d.dco_dc_gen_en = 1'b1;
        gate_d.xtal_en       = 1'b1;
      end
      SLEEP_LEVEL_3: begin
        gate_d.aux_clk_en = 1'b1;
        gate_d.xtal_en    = 1'b1;
      end
      SLEEP_LEVEL_4: begin
        gate_d = '0;
      end
      default: begin
        gate_d = 6'b111111;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 6'b111111;
    end else begin
      gate_q <= gate_d;
    end
  end

  // ==========================================================================
  // registered request towards the cpu
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_q   <= 1'b0;
      vaddr_q <= RESET_VEC_ADDR;
      prio_q  <= VEC_PRIO[VEC_RESET];
    end else begin
      req_q   <= any_req;
      vaddr_q <= pick_addr;
      prio_q  <= pick_prio;
    end
  end

  // ==========================================================================
  // bootloader key decode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bsl_off_q     <= 1'b0;
      bsl_noerase_q <= 1'b0;
    end else begin
      bsl_off_q     <= (bootloader_key_word == BOOT_KEY_DISABLE);
      bsl_noerase_q <= (bootloader_key_word == BOOT_KEY_NO_ERASE);
    end
  end

  // ==========================================================================
  // outputs
  assign avs_readdata           = rdata_q;
  assign avs_waitrequest        = wait_q;
  assign irq_req                = req_q;
  assign vector_word_addr       = vaddr_q;
  assign irq_priority           = prio_q;
  assign fetch_reset            = fetch_reset_q;
  assign bootloader_disable     = bsl_off_q;
  assign bootloader_erase_block = bsl_noerase_q;
  assign clk_gate               = gate_q;

endmodule

// >>> logic/intvec_pkg.sv
// Purpose: shared constants and types for the interrupt vector and low-power controller
// Assumes: 16-bit address space, vector table at the top 64 bytes
// Notes:   register offsets are byte addresses on a 32-bit Avalon-MM slave
package intvec_pkg;

  // ==========================================================================
  // operating modes
  typedef enum logic [2:0] {
    FULL_RUN_MODE = 3'b000,
    SLEEP_LEVEL_0 = 3'b001,
    SLEEP_LEVEL_1 = 3'b010,
    SLEEP_LEVEL_2 = 3'b011,
    SLEEP_LEVEL_3 = 3'b100,
    SLEEP_LEVEL_4 = 3'b101
  } power_mode_e;

  // ==========================================================================
  // vector table, entries ordered from lowest to highest priority
  localparam int NUM_VEC = 12;
  localparam int VEC_RESET = 11;
  localparam int VEC_NMI = 10;
  localparam logic [15:0] VEC_ADDR [NUM_VEC] = '{
    16'hFFE4, 16'hFFE6, 16'hFFEA, 16'hFFEC, 16'hFFEE, 16'hFFF0,
    16'hFFF2, 16'hFFF4, 16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFE};
  localparam logic [4:0] VEC_PRIO [NUM_VEC] = '{
    5'h12, 5'h13, 5'h15, 5'h16, 5'h17, 5'h18,
    5'h19, 5'h1A, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
  localparam logic [15:0] VEC_REGION_BASE = 16'hFFC0;
  localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
  localparam logic [15:0] BLANK_WORD = 16'hFFFF;

  // ==========================================================================
  // memory map for the fetch range check
  localparam logic [15:0] PERIPH_TOP = 16'h01FF;
  localparam logic [15:0] RAM_BASE = 16'h0200;
  localparam logic [15:0] INFO_BASE = 16'h1000;
  localparam logic [15:0] INFO_TOP = 16'h10FF;

  // ==========================================================================
  // bootloader key patterns
  localparam logic [15:0] BOOT_KEY_DISABLE = 16'hAA55;
  localparam logic [15:0] BOOT_KEY_NO_ERASE = 16'h0000;

  // ==========================================================================
  // register map (byte offsets) and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ENABLE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_BOOT = 4'hC;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GIE_BIT = 3;
  localparam int CTRL_DCO_BIT = 4;
  localparam int EN_NMI_PIN_BIT = 10;
  localparam int EN_OSC_BIT = 11;
  localparam int EN_ACCV_BIT = 12;
  localparam int EN_WIDTH = 13;
  localparam logic [12:0] ENABLE_RESET = 13'h0000;

  // ==========================================================================
  // grouped carriers
  typedef struct packed {
    logic       power_up_flag;
    logic       ext_reset_flag;
    logic       watchdog_flag;
    logic       flash_key_violation_flag;
    logic       nonmaskable_pin_flag;
    logic       osc_fault_flag;
    logic       flash_access_violation_flag;
    logic       second_timer_ch0_flag;
    logic       second_timer_shared_flag;
    logic       watchdog_interval_flag;
    logic       first_timer_ch0_flag;
    logic       first_timer_shared_flag;
    logic       serial_rx_flag;
    logic       serial_tx_flag;
    logic       converter_done_flag;
    logic [7:0] port2_pin_flags;
    logic [7:0] port1_pin_flags;
  } src_flags_s;

  typedef struct packed {
    logic cpu_run;
    logic main_clk_en;
    logic sub_main_clk_en;
    logic aux_clk_en;
    logic dco_dc_gen_en;
    logic xtal_en;
  } clk_gate_s;

endpackage

// >>> testbench/intvec_lowpower_ctrl_asserts.sv
// Purpose: port-level checks for the vector and low-power controller
// Assumes: one clock domain, rst_n asynchronous and active low
// Notes:   attached by bind from the bench top file
module intvec_lowpower_ctrl_asserts
  import intvec_pkg::*;
#(
  parameter logic [15:0] RAM_TOP   = 16'h02FF,
  parameter logic [15:0] CODE_BASE = 16'hF800
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire src_flags_s  src_flags,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] bootloader_key_word,
  input wire logic        irq_req,
  input wire logic [15:0] vector_word_addr,
  input wire logic [4:0]  irq_priority,
  input wire logic        fetch_reset,
  input wire logic        bootloader_disable,
  input wire clk_gate_s   clk_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bad_now;
  logic rst_src;
  logic key_hit;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // helper terms
  assign bad_now = fetch_valid && (fetch_addr <= PERIPH_TOP
                   || (fetch_addr > RAM_TOP && fetch_addr < INFO_BASE)
                   || (fetch_addr > INFO_TOP && fetch_addr < CODE_BASE));
  assign rst_src = src_flags.power_up_flag || src_flags.ext_reset_flag
                   || src_flags.watchdog_flag || src_flags.flash_key_violation_flag;
  assign key_hit = bootloader_key_word == BOOT_KEY_DISABLE;
  // wake steps
  sequence asleep_pending;
    irq_req && !clk_gate.cpu_run;
  endsequence
  sequence woken_soon;
    ##[1:2] clk_gate.cpu_run;
  endsequence
  // ==========================================================================
  // clock gating
  chk_run_clocks: assert property (clk_gate.cpu_run |-> clk_gate.main_clk_en
    && clk_gate.sub_main_clk_en && clk_gate.aux_clk_en) else $error("run clocks off");
  chk_light_sleep: assert property (!clk_gate.cpu_run && clk_gate.sub_main_clk_en
    |-> !clk_gate.main_clk_en && clk_gate.aux_clk_en) else $error("light sleep gating");
  chk_mid_sleep: assert property (!clk_gate.cpu_run && !clk_gate.sub_main_clk_en
    && clk_gate.aux_clk_en |-> !clk_gate.main_clk_en) else $error("mid sleep gating");
  chk_deep_off: assert property (!clk_gate.aux_clk_en |-> clk_gate == '0)
    else $error("deep sleep left a clock on");
  chk_wake_run: assert property (asleep_pending |-> woken_soon)
    else $error("core not woken");
  // ==========================================================================
  // vectors and faults
  chk_vec_pair: assert property (irq_req |-> vector_word_addr ==
    VEC_REGION_BASE + {10'h000, irq_priority, 1'b0}) else $error("vector and priority differ");
  chk_vec_used: assert property (irq_req |-> vector_word_addr >= 16'hFFE4
    && vector_word_addr != 16'hFFE8 && vector_word_addr != 16'hFFF6) else $error("unused vector");
  chk_reset_group: assert property (rst_src |=> irq_req && irq_priority == 5'h1F)
    else $error("reset source not served");
  chk_fetch_flag: assert property (1'b1 |=> fetch_reset == $past(bad_now))
    else $error("fetch reset mismatch");
  chk_fault_vec: assert property (fetch_reset |=> irq_req
    && vector_word_addr == RESET_VEC_ADDR) else $error("fetch fault not on reset vector");
  chk_boot_key: assert property (1'b1 |=> bootloader_disable == $past(key_hit))
    else $error("bootloader disable mismatch");
  // ==========================================================================
  // bus handshake
  chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer after one wait");
endmodule

// >>> testbench/cpu_side_model.sv
// Purpose: cpu stand-in that takes vectors and ends handlers
// Assumes: pulses change just after the rising edge
// Notes:   RET_DELAY sets how slowly a handler ends after done
module cpu_side_model
  import intvec_pkg::*;
#(
  parameter int RET_DELAY = 1
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic irq_req,
  input  wire clk_gate_s clk_gate,
  input  wire logic handler_done,
  output logic      cpu_irq_ack,
  output logic      cpu_irq_return
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       seen_q;
  logic [3:0] wait_q;
  // take each request once, only while the core runs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
      cpu_irq_ack <= 1'b0;
    end else begin
      seen_q <= irq_req && clk_gate.cpu_run;
      cpu_irq_ack <= irq_req && clk_gate.cpu_run && !seen_q;
    end
  end
  // return pulse some cycles after the handler is done
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      cpu_irq_return <= 1'b0;
    end else begin
      wait_q <= handler_done ? 4'(RET_DELAY) : (wait_q != 4'h0 ? wait_q - 4'h1 : 4'h0);
      cpu_irq_return <= wait_q == 4'h1;
    end
  end
endmodule

// >>> testbench/intvec_lowpower_ctrl_test.sv
// Purpose: directed bench for the vector and low-power controller
// Assumes: 100 MHz clk_sys, rst_n held 10 cycles
// Notes:   bus accesses wait on waitrequest under a bound
module intvec_lowpower_ctrl_test
  import intvec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  src_flags_s  src_flags = '0;
  logic        fetch_valid = 1'b0;
  logic [15:0] fetch_addr = 16'hF800;
  logic [15:0] boot_vector_word = 16'hF800;
  logic [15:0] bootloader_key_word = 16'h1234;
  logic        handler_done = 1'b0;
  logic        cpu_irq_ack, cpu_irq_return, irq_req, fetch_reset;
  logic        bootloader_disable, bootloader_erase_block;
  logic [15:0] vector_word_addr;
  logic [4:0]  irq_priority;
  clk_gate_s   clk_gate;
  logic [31:0] rd;
  int          err_count = 0;
  int          compares = 0;
  logic [15:0] fetch_tab [10] = '{16'h0000, 16'h0200, 16'h01FF, 16'h02FF, 16'h0300,
                                  16'h1000, 16'h1100, 16'h10FF, 16'hF7FE, 16'hF800};
  logic [15:0] key_tab [3] = '{16'hAA55, 16'h0000, 16'h1234};
  logic [1:0]  boot_tab [3] = '{2'b01, 2'b10, 2'b00};

  // ==========================================================================
  // design and cpu stand-in
  intvec_lowpower_ctrl i_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .src_flags,
    .fetch_valid, .fetch_addr, .cpu_irq_ack, .cpu_irq_return, .boot_vector_word,
    .bootloader_key_word, .irq_req, .vector_word_addr, .irq_priority, .fetch_reset,
    .bootloader_disable, .bootloader_erase_block, .clk_gate);
  cpu_side_model #(.RET_DELAY(3)) i_cpu (.clk_sys, .rst_n, .irq_req, .clk_gate,
    .handler_done, .cpu_irq_ack, .cpu_irq_return);
  initial forever #5 clk_sys = ~clk_sys;

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic at_neg(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic reg_access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic do_reset(input logic [15:0] boot);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    boot_vector_word <= boot;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  function automatic logic [5:0] exp_gate(input int m, input logic internal_tunable_oscillator);
    case (m)
      0: return 6'h3F;
      1: return 6'h0F;
      2: return internal_tunable_oscillator ? 6'h0F : 6'h0D;
      3: return 6'h07;
      4: return 6'h05;
      default: return 6'h00;
    endcase
  endfunction
  function automatic logic [4:0] exp_prio(input int i);
    if (i >= 27) return 5'h1F;
    if (i >= 24) return 5'h1E;
    if (i >= 22) return 5'(i + 6);
    if (i >= 16) return 5'(i + 5);
    return i >= 8 ? 5'h13 : 5'h12;
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    do_reset(16'hF800);
    at_neg(1);
    check(clk_gate, 6'h3F);
    reg_access(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    // every mode code, with and without the oscillator used in run mode
    for (int d = 0; d < 2; d++)
      for (int m = 0; m < 6; m++) begin
        reg_access(1'b1, REG_CTRL, {27'h0, d[0], 1'b0, m[2:0]});
        at_neg(1);
        check(clk_gate, exp_gate(m, d[0]));
      end
    reg_access(1'b1, REG_CTRL, 32'h16);
    at_neg(1);
    check(clk_gate, 6'h00);
    reg_access(1'b1, REG_CTRL, 32'h18);
    reg_access(1'b1, REG_ENABLE, 32'h1FFF);
    // pile up flags from lowest to highest, the top one must win
    for (int i = 0; i < 31; i++) begin
      @(posedge clk_sys);
      src_flags <= 31'((32'h1 << (i + 1)) - 32'h1);
      at_neg(1);
      check(irq_priority, exp_prio(i));
      check(vector_word_addr, 16'hFFC0 + {10'h000, exp_prio(i), 1'b0});
    end
    @(posedge clk_sys);
    src_flags <= '0;
    reg_access(1'b1, REG_CTRL, 32'h10);
    @(posedge clk_sys);
    src_flags.port1_pin_flags <= 8'h80;
    src_flags.nonmaskable_pin_flag <= 1'b1;
    at_neg(1);
    check(irq_priority, 5'h1E);
    reg_access(1'b1, REG_ENABLE, 32'h03FF);
    at_neg(1);
    check(irq_req, 1'b0);
    @(posedge clk_sys);
    src_flags.ext_reset_flag <= 1'b1;
    at_neg(1);
    check(irq_priority, 5'h1F);
    // wake from sleep level 2 and return to it
    @(posedge clk_sys);
    src_flags <= '0;
    reg_access(1'b1, REG_ENABLE, 32'h0001);
    reg_access(1'b1, REG_CTRL, 32'h1B);
    @(posedge clk_sys);
    src_flags.port1_pin_flags <= 8'h01;
    at_neg(2);
    check(clk_gate, 6'h3F);
    // woken flag, run mode, pending request and port 1 priority in status
    reg_access(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h0000_1032);
    @(posedge clk_sys);
    src_flags <= '0;
    handler_done <= 1'b1;
    @(posedge clk_sys);
    handler_done <= 1'b0;
    at_neg(5);
    check(clk_gate, 6'h07);
    // fetches alternate between bad and good places
    reg_access(1'b1, REG_CTRL, 32'h10);
    for (int k = 0; k < 10; k++) begin
      @(posedge clk_sys);
      fetch_valid <= 1'b1;
      fetch_addr <= fetch_tab[k];
      @(posedge clk_sys);
      fetch_valid <= 1'b0;
      at_neg(0);
      check(fetch_reset, !k[0]);
      if (!k[0]) begin
        at_neg(1);
        check(irq_req, 1'b1);
        check(vector_word_addr, RESET_VEC_ADDR);
      end
    end
    // key word patterns at ports and in the register
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_sys);
      bootloader_key_word <= key_tab[j];
      at_neg(1);
      check({bootloader_erase_block, bootloader_disable}, boot_tab[j]);
      reg_access(1'b0, REG_BOOT, 32'h0);
      check(rd, {30'h0, boot_tab[j]});
    end
    do_reset(16'hFFFF);
    at_neg(2);
    check(clk_gate, 6'h00);
    conclude();
  end
endmodule

bind intvec_lowpower_ctrl intvec_lowpower_ctrl_asserts #(.RAM_TOP(RAM_TOP),
  .CODE_BASE(CODE_BASE)) i_chk (.clk_sys, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .src_flags, .fetch_valid, .fetch_addr, .bootloader_key_word, .irq_req, .vector_word_addr,
  .irq_priority, .fetch_reset, .bootloader_disable, .clk_gate);
